// file: design/sleep_pkg.sv
// shared types and constants for the sleep, wake and indicator controller
package sleep_pkg;

    // sleep state encoding
    typedef enum logic [1:0] {
        ST_S0 = 2'b00,
        ST_S1 = 2'b01,
        ST_S4 = 2'b10,
        ST_S5 = 2'b11
    } sleep_state_t;

    // wake sources, one bit each
    typedef struct packed {
        logic power_switch;
        logic rtc_alarm;
        logic pci_pme;
        logic kbd_mouse;
        logic usb;
        logic infrared;
        logic lan;
        logic lan_directed_frame;
    } wake_src_t;

    // power rails steered by the controller
    typedef struct packed {
        logic cpu_run;
        logic main_power;
        logic wake_logic;
    } power_ctl_t;

    // riser indicator outputs
    typedef struct packed {
        logic power_led;
        logic led_green;
        logic led_yellow;
        logic msg_led;
    } led_t;

    // sleep request from power-management software
    typedef struct packed {
        logic         valid;
        sleep_state_t target;
    } sleep_req_t;

    // message blink half period: 250 ms at 125 MHz
    localparam int unsigned CLK_MHZ       = 125;
    localparam int unsigned BLINK_HALF_MS = 250;
    localparam int unsigned BLINK_CYCLES  = BLINK_HALF_MS * 1000 * CLK_MHZ;
    localparam int unsigned BLINK_W       = 25;

    // reset values
    localparam sleep_state_t RESET_STATE = ST_S0;
    localparam logic [BLINK_W-1:0] BLINK_ZERO = 25'h0000000;

endpackage : sleep_pkg

// file: design/sleep_wake_ctl.sv
// sleep state, wake decode and riser indicator controller
`timescale 1ns/1ns

// Functional notes
// - S0: cpu running, all devices powered
// - S1: cpu halted, all devices powered
// - S4: only wake logic stays powered
// - S5: everything unpowered, context lost
// - switch wakes S1/S4/S5; RTC, PME S1/S4
// - keyboard, mouse, USB, IR wake S1 only
// - LAN wakes S1/S4; directed frame ignored
// - single-colour power LED lit only in S0
// - dual LED green in S0, yellow S1
// - dual LED dark in S4 and S5
// - message LED follows message-waiting report
// - option blinks message LED itself
module sleep_wake_ctl #(
    parameter int unsigned BLINK_COUNT = sleep_pkg::BLINK_CYCLES
) (
    input  wire logic                  clk_in,
    input  wire logic                  nrst_in,
    input  wire sleep_pkg::sleep_req_t sleep_req_in,
    input  wire sleep_pkg::wake_src_t  wake_in,
    input  wire logic                  msg_waiting_in,
    input  wire logic                  msg_blink_en_in,
    output logic                       wake_pulse_out,
    output sleep_pkg::sleep_state_t    state_out,
    output sleep_pkg::power_ctl_t      power_out,
    output sleep_pkg::led_t            led_out
);
    import sleep_pkg::*;

    // ****************************************
    // state record
    // ****************************************
    typedef struct packed {
        sleep_state_t         state;
        power_ctl_t           power;
        led_t                 led;
        logic                 wake;
        logic                 blink_phase;
        logic [BLINK_W-1:0]   blink_cnt;
    } ctl_state_t;

    ctl_state_t cur;
    ctl_state_t next_cur;
    logic       wake_ok;

    // ****************************************
    // wake decode and next state
    // ****************************************
    always_comb begin
        next_cur = cur;
        wake_ok  = 1'b0;
        unique case (cur.state)
            ST_S0: wake_ok = 1'b0;
            ST_S1: wake_ok = wake_in.power_switch | wake_in.rtc_alarm | wake_in.pci_pme
                           | wake_in.kbd_mouse | wake_in.usb | wake_in.infrared
                           | wake_in.lan;
            ST_S4: wake_ok = wake_in.power_switch | wake_in.rtc_alarm | wake_in.pci_pme
                           | wake_in.lan;
            ST_S5: wake_ok = wake_in.power_switch;
        endcase
        next_cur.wake = wake_ok;
        if (wake_ok) begin
            next_cur.state = ST_S0;
        end else if (cur.state == ST_S0 && sleep_req_in.valid) begin
            next_cur.state = sleep_req_in.target;
        end
        // power rails per state, from the state being entered
        // rails by state
        unique case (next_cur.state)
            ST_S0: next_cur.power = '{cpu_run: 1'b1, main_power: 1'b1, wake_logic: 1'b1};
            ST_S1: next_cur.power = '{cpu_run: 1'b0, main_power: 1'b1, wake_logic: 1'b1};
            ST_S4: next_cur.power = '{cpu_run: 1'b0, main_power: 1'b0, wake_logic: 1'b1};
            ST_S5: next_cur.power = '{cpu_run: 1'b0, main_power: 1'b0, wake_logic: 1'b0};
        endcase
        // blink timer free runs; phase toggles each half period
        if (cur.blink_cnt >= BLINK_W'(BLINK_COUNT - 1)) begin
            next_cur.blink_cnt   = BLINK_ZERO;
            next_cur.blink_phase = ~cur.blink_phase;
        end else begin
            next_cur.blink_cnt = cur.blink_cnt + BLINK_W'(1);
        end
        next_cur.led.power_led  = (next_cur.state == ST_S0);
        next_cur.led.led_green  = (next_cur.state == ST_S0);
        next_cur.led.led_yellow = (next_cur.state == ST_S1);
        next_cur.led.msg_led    = msg_waiting_in & (~msg_blink_en_in | cur.blink_phase);
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            cur.state       <= RESET_STATE;
            cur.power       <= '{cpu_run: 1'b1, main_power: 1'b1, wake_logic: 1'b1};
            cur.led         <= '{power_led: 1'b1, led_green: 1'b1,
                                 led_yellow: 1'b0, msg_led: 1'b0};
            cur.wake        <= 1'b0;
            cur.blink_phase <= 1'b0;
            cur.blink_cnt   <= BLINK_ZERO;
        end else begin
            cur <= next_cur;
        end
    end

    // outputs straight from flops
    assign state_out      = cur.state;
    assign power_out      = cur.power;
    assign led_out        = cur.led;
    assign wake_pulse_out = cur.wake;

    // ****************************************
    // checks
    // ****************************************
    a_s0_full_power: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        state_out == ST_S0 |-> power_out.cpu_run && power_out.main_power)
        else $error("S0 without full power");
    a_s1_cpu_halt: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        state_out == ST_S1 |-> !power_out.cpu_run && power_out.main_power)
        else $error("S1 power wrong");
    a_s4_wake_only: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        state_out == ST_S4 |-> !power_out.main_power && power_out.wake_logic)
        else $error("S4 power wrong");
    a_s5_all_off: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        state_out == ST_S5 |-> !power_out.main_power && !power_out.wake_logic)
        else $error("S5 power wrong");
    a_switch_wakes: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        state_out != ST_S0 && wake_in.power_switch |=> state_out == ST_S0 && wake_pulse_out)
        else $error("switch did not wake");
    a_s4_kbd_ignored: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        state_out == ST_S4 && wake_in == wake_src_t'{kbd_mouse: 1'b1, default: 1'b0}
        |=> state_out == ST_S4)
        else $error("keyboard woke from S4");
    a_frame_ignored: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        state_out == ST_S1 && wake_in == wake_src_t'{lan_directed_frame: 1'b1, default: 1'b0}
        && !sleep_req_in.valid |=> state_out == ST_S1)
        else $error("directed frame woke board");
    a_single_led: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        led_out.power_led == (state_out == ST_S0))
        else $error("power led mismatch");
    a_dual_yellow: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        led_out.led_yellow == (state_out == ST_S1) && led_out.led_green == (state_out == ST_S0))
        else $error("dual led colour wrong");
    a_dual_dark: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        state_out inside {ST_S4, ST_S5} |-> !led_out.led_green && !led_out.led_yellow)
        else $error("dual led lit when off");
    a_msg_steady: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        !msg_blink_en_in |=> led_out.msg_led == $past(msg_waiting_in))
        else $error("message led wrong");
    a_msg_blink_off: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        !msg_waiting_in |=> !led_out.msg_led)
        else $error("message led lit without message");
    a_s5_rtc_ignored: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        state_out == ST_S5 && !wake_in.power_switch |=> state_out == ST_S5)
        else $error("illegal wake from S5");

    // ****************************************
    // wake source and request checks
    // ****************************************
    // one pulse per accepted wake
    a_pulse_one_cycle: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        wake_pulse_out |=> !wake_pulse_out)
        else $error("wake pulse longer than one cycle");
    a_s4_alarm_wakes: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        state_out == ST_S4 && (wake_in.rtc_alarm || wake_in.pci_pme) |=> state_out == ST_S0)
        else $error("alarm or pme did not wake from S4");
    a_s1_port_wakes: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        state_out == ST_S1 && (wake_in.kbd_mouse || wake_in.usb || wake_in.infrared)
        |=> state_out == ST_S0 && wake_pulse_out)
        else $error("port event did not wake from S1");
    a_s4_ports_ignored: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        state_out == ST_S4 && !wake_in.power_switch && !wake_in.rtc_alarm
        && !wake_in.pci_pme && !wake_in.lan |=> state_out == ST_S4)
        else $error("unpowered port woke from S4");
    a_s4_lan_wakes: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        state_out == ST_S4 && wake_in.lan |=> state_out == ST_S0)
        else $error("lan did not wake from S4");
    a_sleep_taken: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        state_out == ST_S0 && sleep_req_in.valid |=> state_out == $past(sleep_req_in.target))
        else $error("sleep request not taken");
    a_sleep_holds: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        state_out != ST_S0 && wake_in == '0 |=> $stable(state_out))
        else $error("sleep state left without a wake");
    a_pulse_from_sleep: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        wake_pulse_out |-> state_out == ST_S0 && $past(state_out) != ST_S0)
        else $error("wake pulse from the working state");

endmodule : sleep_wake_ctl

// file: dv/os_wake_model.sv
// partner model: power-management software and wake sources
`timescale 1ns/1ns
module os_wake_model (
    input  wire logic             clk_in,
    output sleep_pkg::sleep_req_t sleep_req_out,
    output sleep_pkg::wake_src_t  wake_out
);
    import sleep_pkg::*;
    // idle: no request, no wake source active
    initial begin
        sleep_req_out = '0;
        wake_out      = '0;
    end
    // one-cycle request so a held level cannot be seen twice
    task automatic ask_sleep(input sleep_state_t s);
        @(posedge clk_in);
        sleep_req_out <= '{valid: 1'b1, target: s};
        @(posedge clk_in);
        sleep_req_out <= '0;
    endtask : ask_sleep
    // one-cycle event on the chosen wake sources
    task automatic pulse_wake(input logic [7:0] w);
        @(posedge clk_in);
        wake_out <= w;
        @(posedge clk_in);
        wake_out <= '0;
    endtask : pulse_wake
endmodule : os_wake_model

// file: dv/sleep_wake_indicator_control_tb_top.sv
// self-checking bench for the sleep, wake and indicator controller
`timescale 1ns/1ns
module sleep_wake_indicator_control_tb_top;
    import sleep_pkg::*;
    // short blink half period keeps the run brief
    localparam int unsigned BLINK = 4;
    logic         clk_in = 1'b0;
    logic         nrst_in = 1'b0;
    logic         msg_waiting = 1'b0;
    logic         msg_blink_en = 1'b0;
    sleep_req_t   req;
    wake_src_t    wake;
    logic         pulse;
    sleep_state_t st;
    power_ctl_t   pwr;
    led_t         led;
    int           err_total = 0;
    int           checks = 0;
    int           cycles = 0;
    // expected rails, leds and accepted wake sources per state
    logic [2:0] pwr_exp [4] = '{3'h7, 3'h3, 3'h1, 3'h0};
    logic [3:0] led_exp [4] = '{4'hC, 4'h2, 4'h0, 4'h0};
    logic [7:0] wake_ok [4] = '{8'h00, 8'hFE, 8'hE2, 8'h80};
    always #4 clk_in = ~clk_in;
    sleep_wake_ctl #(.BLINK_COUNT(BLINK)) sleep_wake_ctl_inst (.clk_in(clk_in),
        .nrst_in(nrst_in), .sleep_req_in(req), .wake_in(wake),
        .msg_waiting_in(msg_waiting), .msg_blink_en_in(msg_blink_en),
        .wake_pulse_out(pulse), .state_out(st), .power_out(pwr), .led_out(led));
    os_wake_model os_wake_model_inst (.clk_in(clk_in), .sleep_req_out(req), .wake_out(wake));
    // ****************************************
    // compare, closing report and hang guard
    // ****************************************
    task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    task automatic wrap_up;
        $display("mismatches %0d comparisons %0d", err_total, checks);
        if (err_total == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up
    // the whole run needs well under a thousand cycles
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_total++;
            wrap_up();
        end
    end
    task automatic check_state(input int s);
        cmp("state", 8'(s), 8'(st));
        cmp("power", 8'(pwr_exp[s]), 8'(pwr));
        cmp("leds", 8'(led_exp[s]), 8'(led));
    endtask : check_state
    // every source from every state, refused ones must leave state alone
    task automatic test_wake_table;
        logic ok;
        for (int s = 0; s < 4; s++) begin
            for (int b = 0; b < 8; b++) begin
                os_wake_model_inst.ask_sleep(sleep_state_t'(s));
                #1;
                check_state(s);
                os_wake_model_inst.pulse_wake(8'h01 << b);
                #1;
                ok = wake_ok[s][b];
                cmp("wake pulse", 8'(ok), 8'(pulse));
                cmp("wake state", ok ? 8'h00 : 8'(s), 8'(st));
                if (!ok) os_wake_model_inst.pulse_wake(8'h80);
            end
        end
    endtask : test_wake_table
    // steady, then blinking, then cleared message indicator
    task automatic test_msg_led;
        int ones;
        ones = 0;
        @(posedge clk_in) msg_waiting <= 1'b1;
        repeat (2) @(posedge clk_in);
        #1 cmp("msg steady", 8'h01, 8'(led.msg_led));
        @(posedge clk_in) msg_blink_en <= 1'b1;
        repeat (12) begin
            @(posedge clk_in);
            #1 ones += int'(led.msg_led === 1'b1);
        end
        cmp("msg blink", 8'h01, 8'(ones > 0 && ones < 12));
        @(posedge clk_in) msg_waiting <= 1'b0;
        repeat (2) @(posedge clk_in);
        #1 cmp("msg clear", 8'h00, 8'(led.msg_led));
    endtask : test_msg_led
    // a sleep request outside S0 is refused; the switch brings the board back
    task automatic test_refused_req;
        os_wake_model_inst.ask_sleep(ST_S1);
        #1 check_state(1);
        os_wake_model_inst.ask_sleep(ST_S4);
        #1 check_state(1);
        os_wake_model_inst.pulse_wake(8'h80);
        #1 check_state(0);
    endtask : test_refused_req
    // reset from deep sleep: reset values while held and after release
    task automatic test_reset_mid;
        os_wake_model_inst.ask_sleep(ST_S4);
        #1 check_state(2);
        @(posedge clk_in) nrst_in <= 1'b0;
        @(posedge clk_in);
        #1 check_state(0);
        @(posedge clk_in) nrst_in <= 1'b1;
        @(posedge clk_in);
        #1 check_state(0);
        cmp("wake pulse", 8'h00, 8'(pulse));
    endtask : test_reset_mid
    initial begin
        repeat (16) @(posedge clk_in);
        nrst_in <= 1'b1;
        @(posedge clk_in);
        #1 check_state(0);
        test_wake_table();
        test_refused_req();
        test_reset_mid();
        test_msg_led();
        wrap_up();
    end
endmodule : sleep_wake_indicator_control_tb_top
